//--- rtl/lad_pkg.sv
package lad_pkg;

	// ------------------------------------------------------------
	// Opcode patterns and masks
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_FIX_MUL = 8'hD4;
	localparam logic [7:0] OPC_FIX_DIV = 8'hD5;
	localparam logic [7:0] FIX_TAIL = 8'h0A;
	localparam logic [7:0] OPC_SEXT_BW = 8'h98;
	localparam logic [7:0] OPC_SEXT_WD = 8'h99;
	localparam logic [7:0] OPC_AND_RM = 8'h20;
	localparam logic [7:0] MSK_AND_RM = 8'hFC;
	localparam logic [7:0] OPC_TEST_RM = 8'hF6;
	localparam logic [7:0] OPC_TEST_ACC = 8'hA8;
	localparam logic [7:0] MSK_W = 8'hFE;
	localparam logic [7:0] OPC_SHIFT_ONE = 8'hD0;
	localparam logic [7:0] MSK_SHIFT_ONE = 8'hFC;
	localparam logic [7:0] OPC_SHIFT_CNT = 8'hC0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_W = 0;
	localparam int BIT_D = 1;
	localparam int MOD_HI = 7;
	localparam int MOD_LO = 6;
	localparam int FLD_HI = 5;
	localparam int FLD_LO = 3;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] FLD_TEST = 3'h0;

	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [5:0] CYC_FIX_MUL = 6'h13;
	localparam logic [5:0] CYC_FIX_DIV = 6'h0F;
	localparam logic [5:0] CYC_SEXT_BW = 6'h02;
	localparam logic [5:0] CYC_SEXT_WD = 6'h04;
	localparam logic [5:0] CYC_AND_REG = 6'h03;
	localparam logic [5:0] CYC_AND_MEM = 6'h0A;
	localparam logic [5:0] CYC_TRM_REG = 6'h04;
	localparam logic [5:0] CYC_TRM_MEM = 6'h0A;
	localparam logic [5:0] CYC_TACC_B = 6'h03;
	localparam logic [5:0] CYC_TACC_W = 6'h04;
	localparam logic [5:0] CYC_NONE = 6'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CL_NONE = 4'h0,
		CL_FIX_MUL = 4'h1,
		CL_FIX_DIV = 4'h2,
		CL_SEXT_BW = 4'h3,
		CL_SEXT_WD = 4'h4,
		CL_AND_RM = 4'h5,
		CL_TEST_RM = 4'h6,
		CL_TEST_ACC = 4'h7,
		CL_SHIFT = 4'h8
	} lad_class_e;

	typedef enum logic [2:0] {
		rotate_left = 3'h0,
		rotate_right = 3'h1,
		rotate_left_through_carry = 3'h2,
		rotate_right_through_carry = 3'h3,
		shift_left = 3'h4,
		shift_op_reserved = 3'h6,
		logical_shift_right = 3'h5,
		arithmetic_shift_right = 3'h7
	} lad_shift_e;

	typedef enum logic [3:0] {
		ST_OPC = 4'h1,
		ST_MODRM = 4'h2,
		ST_IMM_LO = 4'h4,
		ST_IMM_HI = 4'h8
	} lad_state_e;

endpackage

//--- rtl/lad_decode.sv
// What this block does
// - Opcode D4 then 0A is ascii fix after multiply, 19 cycles.
// - Opcode D5 then 0A is ascii fix before divide, 15 cycles.
// - Opcode 98 sign-extends low accumulator byte to word, 2 cycles.
// - Opcode 99 sign-extends accumulator into data register pair, 4 cycles.
// - Three-bit field of shift addressing byte selects the shift or rotate.
// - Pattern 001000dw with addressing byte is register AND, 3 or 10 cycles.
// - Test forms only update flags and never write a destination.
// - Pattern 1111011w, field 000, immediate: test operand, 4 or 10 cycles.
// - Pattern 1010100w with immediate tests accumulator, 3 or 4 cycles.
module lad_decode
	import lad_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	output logic dec_valid_r,
	output lad_class_e dec_class_r,
	output logic [5:0] dec_cycles_r,
	output logic dec_word_r,
	output logic dec_dest_reg_r,
	output logic dec_writes_r,
	output logic dec_flags_only_r,
	output lad_shift_e dec_shift_op_r,
	output logic [15:0] dec_imm_r
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic is_shift(input logic [7:0] opc);
		return ((opc & MSK_SHIFT_ONE) == OPC_SHIFT_ONE) || ((opc & MSK_W) == OPC_SHIFT_CNT);
	endfunction

	function automatic lad_class_e classify(input logic [7:0] opc, input logic [7:0] mrm);
		lad_class_e c;
		c = CL_NONE;
		if ((opc == OPC_FIX_MUL) && (mrm == FIX_TAIL)) begin
			c = CL_FIX_MUL;
		end else if ((opc == OPC_FIX_DIV) && (mrm == FIX_TAIL)) begin
			c = CL_FIX_DIV;
		end else if (opc == OPC_SEXT_BW) begin
			c = CL_SEXT_BW;
		end else if (opc == OPC_SEXT_WD) begin
			c = CL_SEXT_WD;
		end else if ((opc & MSK_AND_RM) == OPC_AND_RM) begin
			c = CL_AND_RM;
		end else if (((opc & MSK_W) == OPC_TEST_RM) && (mrm[FLD_HI:FLD_LO] == FLD_TEST)) begin
			c = CL_TEST_RM;
		end else if ((opc & MSK_W) == OPC_TEST_ACC) begin
			c = CL_TEST_ACC;
		end else if (is_shift(opc)) begin
			c = CL_SHIFT;
		end
		return c;
	endfunction

	function automatic logic [5:0] cycles_of(input lad_class_e c, input logic [7:0] opc,
			input logic [7:0] mrm);
		logic reg_op;
		reg_op = (mrm[MOD_HI:MOD_LO] == MOD_REG);
		case (c)
			CL_FIX_MUL: return CYC_FIX_MUL;
			CL_FIX_DIV: return CYC_FIX_DIV;
			CL_SEXT_BW: return CYC_SEXT_BW;
			CL_SEXT_WD: return CYC_SEXT_WD;
			CL_AND_RM: return reg_op ? CYC_AND_REG : CYC_AND_MEM;
			CL_TEST_RM: return reg_op ? CYC_TRM_REG : CYC_TRM_MEM;
			CL_TEST_ACC: return opc[BIT_W] ? CYC_TACC_W : CYC_TACC_B;
			default: return CYC_NONE;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Byte sequencing
	// ------------------------------------------------------------
	lad_state_e state_r;
	logic [7:0] opc_r;
	logic [7:0] mrm_r;
	logic [7:0] imm_lo_r;
	logic [7:0] cur_opc;
	logic [7:0] cur_mrm;
	logic need_mrm;
	logic need_imm;
	logic imm_two;
	logic fin;
	lad_class_e fin_class;
	logic step;

	assign step = ce && byte_valid;
	assign cur_opc = (state_r == ST_OPC) ? byte_in : opc_r;
	// One-byte opcodes see a zero addressing byte, so no field of the last instruction leaks out.
	assign cur_mrm = (state_r == ST_MODRM) ? byte_in : ((state_r == ST_OPC) ? 8'h00 : mrm_r);
	assign need_mrm = (cur_opc == OPC_FIX_MUL) || (cur_opc == OPC_FIX_DIV) ||
		((cur_opc & MSK_AND_RM) == OPC_AND_RM) || ((cur_opc & MSK_W) == OPC_TEST_RM) ||
		is_shift(cur_opc);
	assign need_imm = (((cur_opc & MSK_W) == OPC_TEST_RM) &&
		(cur_mrm[FLD_HI:FLD_LO] == FLD_TEST)) || ((cur_opc & MSK_W) == OPC_SHIFT_CNT);
	// A shift count is always one byte; test immediates follow the width bit.
	assign imm_two = cur_opc[BIT_W] && ((cur_opc & MSK_W) != OPC_SHIFT_CNT);
	assign fin_class = classify(cur_opc, cur_mrm);

	always_comb begin
		case (state_r)
			ST_OPC: fin = !need_mrm && ((byte_in & MSK_W) != OPC_TEST_ACC);
			ST_MODRM: fin = !need_imm;
			ST_IMM_LO: fin = !imm_two;
			ST_IMM_HI: fin = 1'b1;
			default: fin = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_OPC;
		end else if (step) begin
			case (state_r)
				ST_OPC: begin
					if ((byte_in & MSK_W) == OPC_TEST_ACC) begin
						state_r <= ST_IMM_LO;
					end else if (need_mrm) begin
						state_r <= ST_MODRM;
					end
				end
				ST_MODRM: state_r <= need_imm ? ST_IMM_LO : ST_OPC;
				ST_IMM_LO: state_r <= imm_two ? ST_IMM_HI : ST_OPC;
				ST_IMM_HI: state_r <= ST_OPC;
				default: state_r <= ST_OPC;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			opc_r <= 8'h00;
			mrm_r <= 8'h00;
			imm_lo_r <= 8'h00;
		end else if (step) begin
			if (state_r == ST_OPC) begin
				opc_r <= byte_in;
				mrm_r <= 8'h00;
			end
			if (state_r == ST_MODRM) begin
				mrm_r <= byte_in;
			end
			if (state_r == ST_IMM_LO) begin
				imm_lo_r <= byte_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Decoded result
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dec_valid_r <= 1'b0;
			dec_class_r <= CL_NONE;
			dec_cycles_r <= CYC_NONE;
			dec_word_r <= 1'b0;
			dec_dest_reg_r <= 1'b0;
			dec_writes_r <= 1'b0;
			dec_flags_only_r <= 1'b0;
			dec_shift_op_r <= rotate_left;
			dec_imm_r <= 16'h0000;
		end else if (ce) begin
			dec_valid_r <= step && fin;
			if (step && fin) begin
				dec_class_r <= fin_class;
				dec_cycles_r <= cycles_of(fin_class, cur_opc, cur_mrm);
				case (fin_class)
					CL_SEXT_BW, CL_SEXT_WD: dec_word_r <= 1'b1;
					CL_AND_RM, CL_TEST_RM, CL_TEST_ACC, CL_SHIFT: begin
						dec_word_r <= cur_opc[BIT_W];
					end
					default: dec_word_r <= 1'b0;
				endcase
				dec_dest_reg_r <= (fin_class == CL_AND_RM) && cur_opc[BIT_D];
				dec_writes_r <= (fin_class != CL_NONE) && (fin_class != CL_TEST_RM) &&
					(fin_class != CL_TEST_ACC);
				dec_flags_only_r <= (fin_class == CL_TEST_RM) ||
					(fin_class == CL_TEST_ACC);
				dec_shift_op_r <= lad_shift_e'(cur_mrm[FLD_HI:FLD_LO]);
				case (state_r)
					ST_IMM_LO: dec_imm_r <= {8'h00, byte_in};
					ST_IMM_HI: dec_imm_r <= {byte_in, imm_lo_r};
					default: dec_imm_r <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_fix_mul_cyc: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_FIX_MUL) |-> (dec_cycles_r == 6'h13) &&
		(mrm_r == FIX_TAIL))
		else $error("ascii fix after multiply decoded wrongly");
	chk_fix_div_cyc: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_FIX_DIV) |-> (dec_cycles_r == 6'h0F) &&
		!dec_flags_only_r)
		else $error("ascii fix before divide decoded wrongly");
	chk_sext_bw: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && byte_valid && (state_r == ST_OPC) && (byte_in == 8'h98) |=>
		dec_valid_r && (dec_class_r == CL_SEXT_BW) && (dec_cycles_r == 6'h02))
		else $error("byte sign extend not decoded in one byte");
	chk_sext_wd: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && byte_valid && (state_r == ST_OPC) && (byte_in == 8'h99) |=>
		dec_valid_r && (dec_class_r == CL_SEXT_WD) && (dec_cycles_r == 6'h04))
		else $error("word sign extend not decoded in one byte");
	chk_shift_field: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_SHIFT) |->
		(dec_shift_op_r == lad_shift_e'(mrm_r[5:3])))
		else $error("shift operation does not follow the addressing byte");
	chk_and_cycles: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_AND_RM) |->
		(dec_cycles_r == ((mrm_r[7:6] == 2'h3) ? 6'h03 : 6'h0A)) && dec_writes_r)
		else $error("register AND cycle count wrong");
	chk_test_nowrite: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && dec_flags_only_r |-> !dec_writes_r && !dec_dest_reg_r &&
		((dec_class_r == CL_TEST_RM) || (dec_class_r == CL_TEST_ACC)))
		else $error("test form would write a destination");
	chk_test_rm_seq: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && byte_valid && (state_r == ST_MODRM) && ((opc_r & 8'hFE) == 8'hF6) &&
		(byte_in[5:3] == 3'h0) |=> (state_r == ST_IMM_LO) && !dec_valid_r)
		else $error("test immediate did not wait for its data");
	chk_test_acc_cyc: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_TEST_ACC) |->
		(dec_cycles_r == (dec_word_r ? 6'h04 : 6'h03)))
		else $error("accumulator test cycle count wrong");
	// A valid held by a low clock enable is stale, so only a freshly set one is checked.
	chk_imm_width: assert property (@(posedge core_clk) disable iff (!rstn)
		$past(ce) && dec_valid_r && dec_flags_only_r && !dec_word_r |->
		(dec_imm_r[15:8] == 8'h00) && ($past(state_r) == ST_IMM_LO))
		else $error("byte test took more than one immediate byte");
	chk_dest_dir: assert property (@(posedge core_clk) disable iff (!rstn)
		dec_valid_r && (dec_class_r == CL_AND_RM) |-> (dec_dest_reg_r == opc_r[1]))
		else $error("direction bit not honoured");

endmodule

//--- tb/lad_decode_tb_top.sv
module lad_decode_tb_top
	import lad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		lad_class_e cls;
		logic [5:0] cyc;
		logic word;
		logic dest;
		logic wr;
		logic fo;
		lad_shift_e sh;
		logic [15:0] imm;
		logic full;
	} lad_exp_s;

	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic byte_valid = 1'b0;
	logic [7:0] byte_in = 8'h00;
	logic dec_valid_r;
	lad_class_e dec_class_r;
	logic [5:0] dec_cycles_r;
	logic dec_word_r;
	logic dec_dest_reg_r;
	logic dec_writes_r;
	logic dec_flags_only_r;
	lad_shift_e dec_shift_op_r;
	logic [15:0] dec_imm_r;
	int error_cnt = 0;
	int checks = 0;
	logic [39:0] corner [14] = '{40'hA934120000, 40'hA87F000000, 40'hD40A000000, 40'hD50A000000,
		40'hD50B000000, 40'h9800000000, 40'h9900000000, 40'h22C1000000, 40'h2105000000,
		40'hF705CDAB00, 40'hF6C25A0000, 40'hF7C8000000, 40'hC1E3070000, 40'h9000000000};
	logic [7:0] ops [18] = '{8'hD4, 8'hD5, 8'h98, 8'h99, 8'h20, 8'h21, 8'h22, 8'h23, 8'hF6,
		8'hF7, 8'hA8, 8'hA9, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1};
	logic [7:0] b [5];

	lad_decode uut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .byte_valid(byte_valid),
		.byte_in(byte_in), .dec_valid_r(dec_valid_r), .dec_class_r(dec_class_r),
		.dec_cycles_r(dec_cycles_r), .dec_word_r(dec_word_r), .dec_dest_reg_r(dec_dest_reg_r),
		.dec_writes_r(dec_writes_r), .dec_flags_only_r(dec_flags_only_r),
		.dec_shift_op_r(dec_shift_op_r), .dec_imm_r(dec_imm_r));

	always #10 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// Expectation and checking
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic int len_of(input logic [7:0] op, input logic [7:0] m);
		if (op inside {8'hD4, 8'hD5, 8'h20, 8'h21, 8'h22, 8'h23, 8'hD0, 8'hD1, 8'hD2, 8'hD3})
			return 2;
		if (op inside {8'hC0, 8'hC1})
			return 3;
		if (op inside {8'hA8, 8'hA9})
			return 2 + int'(op[0]);
		if (op inside {8'hF6, 8'hF7})
			return (m[5:3] == 3'h0) ? 3 + int'(op[0]) : 2;
		return 1;
	endfunction

	function automatic lad_exp_s exp_of(input logic [7:0] v [5]);
		lad_exp_s e;
		logic w;
		logic rg;
		e = '0;
		w = v[0][0];
		rg = (v[1][7:6] == 2'h3);
		e.full = 1'b1;
		e.wr = 1'b1;
		e.word = w;
		casez (v[0])
			8'b1101010?: begin
				e.word = 1'b0;
				e.full = (v[1] == 8'h0A);
				e.cls = w ? CL_FIX_DIV : CL_FIX_MUL;
				e.cyc = w ? 6'h0F : 6'h13;
			end
			8'b1001100?: begin
				e.word = 1'b1;
				e.cls = w ? CL_SEXT_WD : CL_SEXT_BW;
				e.cyc = w ? 6'h04 : 6'h02;
			end
			8'b001000??: begin
				e.cls = CL_AND_RM;
				e.cyc = rg ? 6'h03 : 6'h0A;
				e.dest = v[0][1];
			end
			8'b1111011?: begin
				e.full = (v[1][5:3] == 3'h0);
				e.cls = CL_TEST_RM;
				e.cyc = rg ? 6'h04 : 6'h0A;
				e.wr = 1'b0;
				e.fo = 1'b1;
				e.imm = w ? {v[3], v[2]} : {8'h00, v[2]};
			end
			8'b1010100?: begin
				e.cls = CL_TEST_ACC;
				e.cyc = w ? 6'h04 : 6'h03;
				e.wr = 1'b0;
				e.fo = 1'b1;
				e.imm = w ? {v[2], v[1]} : {8'h00, v[1]};
			end
			8'b110100??, 8'b1100000?: begin
				e.cls = CL_SHIFT;
				e.sh = lad_shift_e'(v[1][5:3]);
				e.imm = (v[0][7:4] == 4'hC) ? {8'h00, v[2]} : 16'h0000;
			end
			default: e.full = 1'b0;
		endcase
		if (!e.full) begin
			e.cls = CL_NONE;
			e.cyc = 6'h00;
		end
		return e;
	endfunction

	// Bytes go in with random stall cycles; a stalled byte must be ignored.
	task automatic run(input logic [7:0] v [5]);
		lad_exp_s e;
		int n;
		int r;
		n = len_of(v[0], v[1]);
		e = exp_of(v);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			if (i > 0 && $urandom_range(3) == 0) begin
				r = $urandom_range(2);
				ce <= (r == 2);
				byte_valid <= (r == 1);
				byte_in <= 8'($urandom);
				@(posedge core_clk);
			end
			ce <= 1'b1;
			byte_valid <= 1'b1;
			byte_in <= v[i];
			if (i > 0) begin
				#1;
				chk(dec_valid_r, 1'b0);
			end
		end
		@(posedge core_clk);
		byte_valid <= 1'b0;
		byte_in <= ~v[n - 1];
		#1;
		chk(dec_valid_r, 1'b1);
		chk(dec_class_r, e.cls);
		chk(dec_cycles_r, e.cyc);
		if (e.full) begin
			chk(dec_word_r, e.word);
			chk(dec_dest_reg_r, e.dest);
			chk({dec_writes_r, dec_flags_only_r}, {e.wr, e.fo});
			chk(dec_imm_r, e.imm);
		end
		if (e.cls == CL_SHIFT)
			chk(dec_shift_op_r, e.sh);
		@(posedge core_clk);
		#1;
		chk(dec_valid_r, 1'b0);
		chk(dec_cycles_r, e.cyc);
	endtask

	task automatic final_report();
		$display("error_cnt=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hC34C839E));
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk({dec_valid_r, dec_class_r, dec_cycles_r, dec_writes_r}, 16'h0000);
		for (int c = 0; c < 14; c++) begin
			for (int i = 0; i < 5; i++)
				b[i] = corner[c][39 - 8 * i -: 8];
			run(b);
		end
		for (int f = 0; f < 8; f++) begin
			b = '{8'hD1, {2'h3, 3'(f), 3'h2}, 8'h00, 8'h00, 8'h00};
			run(b);
		end
		repeat (300) begin
			for (int i = 0; i < 5; i++)
				b[i] = 8'($urandom);
			b[0] = ops[$urandom_range(17)];
			if (b[0][7:1] == 7'h6A && $urandom_range(3) != 0)
				b[1] = 8'h0A;
			run(b);
		end
		final_report();
	end
endmodule
